// [src/can_phy_defs.svh]
// constants for the transceiver fault and wake-up control
`ifndef CAN_PHY_DEFS_SVH
`define CAN_PHY_DEFS_SVH

// ----------------------------------------------------------------
// clock and time conversion
// ----------------------------------------------------------------
`define CLK_MHZ 125
// least time in ns, rounded up to whole cycles
`define CYC_MIN(ns) ((((ns) * `CLK_MHZ) + 999) / 1000)

// ----------------------------------------------------------------
// times in ns and derived cycle counts
// ----------------------------------------------------------------
`define DOM_TIMEOUT_NS 4000
`define DOM_TIMEOUT_CYC `CYC_MIN(`DOM_TIMEOUT_NS)
`define WAKE_MIN_NS 1000
`define WAKE_MIN_CYC `CYC_MIN(`WAKE_MIN_NS)
`define RECOVER_NS 1000
`define RECOVER_CYC `CYC_MIN(`RECOVER_NS)
`define RETRY_NS 2000
`define RETRY_CYC `CYC_MIN(`RETRY_NS)
`define CNT_W 10

// ----------------------------------------------------------------
// levels and wake filter selections
// ----------------------------------------------------------------
`define RECESSIVE 1'h1
`define DOMINANT 1'h0
`define SEL_OFF 2'h0
`define SEL_MASK1 2'h1
`define SEL_PASS 2'h2
`define SEL_MASK2 2'h3
`define EVT_NONE 2'h0
`define EVT_ONE 2'h1
`define EVT_TWO 2'h2

`endif

// [src/can_phy_pkg.sv]
// types shared by the transceiver control modules
package can_phy_pkg;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic hi_high;
      logic hi_low;
      logic lo_high;
      logic lo_low;
   } volt_t;

   typedef struct packed {
      logic hi;
      logic lo;
   } oc_t;

   typedef struct packed {
      logic hi_line_volt_high_flag;
      logic hi_line_volt_low_flag;
      logic lo_line_volt_high_flag;
      logic lo_line_volt_low_flag;
      logic dom_timeout_flag;
      logic hi_line_overcurrent_flag;
      logic lo_line_overcurrent_flag;
   } flags_t;

   // ----------------------------------------------------------------
   // state machines
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      MODE_SHUTDOWN = 3'h0,
      MODE_NORMAL = 3'h1,
      MODE_PSEUDO = 3'h3,
      MODE_LISTEN = 3'h2,
      MODE_STANDBY = 3'h6
   } mode_t;

   typedef enum logic [1:0] {
      WK_IDLE = 2'h0,
      WK_DOM = 2'h1,
      WK_REC = 2'h3
   } wake_phase_t;

   typedef struct packed {
      wake_phase_t phase;
      logic [9:0] cnt;
      logic [1:0] events;
   } wake_state_t;

   typedef struct packed {
      mode_t mode;
      mode_t saved;
      volt_t vstat;
      oc_t oc_prev;
      logic dt_stat;
      flags_t flags;
      logic dt_lock;
      logic [9:0] dt_cnt;
      logic [9:0] rec_cnt;
      logic rec_busy;
      logic retry_busy;
      logic rx;
   } ctrl_state_t;

endpackage

// [src/wake_pulse_filter.sv]
// wake-up event counter that masks the first events after stop entry
`timescale 1ns/100ps
`include "can_phy_defs.svh"

module wake_pulse_filter (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_armed,
   input wire logic [1:0] i_sel,
   input wire logic i_rx,
   output logic o_rx
);
   can_phy_pkg::wake_state_t s_q;
   can_phy_pkg::wake_state_t s_d;
   logic [1:0] need;

   // ----------------------------------------------------------------
   // event qualification
   // ----------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      case (i_sel)
         `SEL_MASK1: need = `EVT_ONE;
         `SEL_MASK2: need = `EVT_TWO;
         default: need = `EVT_NONE;
      endcase
      // only counts once stop is really entered
      if (!i_armed) begin
         s_d.phase = can_phy_pkg::WK_IDLE;
         s_d.cnt = '0;
         s_d.events = `EVT_NONE;
      end else begin
         case (s_q.phase)
            can_phy_pkg::WK_IDLE: begin
               if (i_rx == `DOMINANT) begin
                  s_d.phase = can_phy_pkg::WK_DOM;
                  s_d.cnt = `CNT_W'(1);
               end
            end
            can_phy_pkg::WK_DOM: begin
               if (i_rx == `DOMINANT) begin
                  if (s_q.cnt != `CNT_W'(`WAKE_MIN_CYC)) begin
                     s_d.cnt = s_q.cnt + `CNT_W'(1);
                  end
               end else if (s_q.cnt == `CNT_W'(`WAKE_MIN_CYC)) begin
                  s_d.phase = can_phy_pkg::WK_REC;
                  s_d.cnt = `CNT_W'(1);
               end else begin
                  s_d.phase = can_phy_pkg::WK_IDLE;
               end
            end
            can_phy_pkg::WK_REC: begin
               if (i_rx == `DOMINANT) begin
                  s_d.phase = can_phy_pkg::WK_DOM;
                  s_d.cnt = `CNT_W'(1);
               end else if (s_q.cnt == `CNT_W'(`WAKE_MIN_CYC)) begin
                  s_d.phase = can_phy_pkg::WK_IDLE;
                  if (s_q.events != `EVT_TWO) begin
                     s_d.events = s_q.events + `EVT_ONE;
                  end
               end else begin
                  s_d.cnt = s_q.cnt + `CNT_W'(1);
               end
            end
            default: s_d.phase = can_phy_pkg::WK_IDLE;
         endcase
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         s_q <= '{phase: can_phy_pkg::WK_IDLE, cnt: '0, events: `EVT_NONE};
      end else begin
         s_q <= s_d;
      end
   end

   // held recessive until enough events have passed
   assign o_rx = (!i_armed || s_q.events >= need) ? i_rx : `RECESSIVE;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   property p_mask_hold;
      @(posedge i_clock) disable iff (i_rst)
      (i_armed && i_sel == `SEL_MASK2 && s_q.events == `EVT_ONE) |-> o_rx == `RECESSIVE;
   endproperty
   a_mask_hold: assert property (p_mask_hold) else $error("masked event passed");
endmodule

// [src/can_phy_fault_wakeup_ctrl.sv]
// transceiver mode, fault, timeout and wake-up control
`timescale 1ns/100ps
`include "can_phy_defs.svh"

// Functional notes
// - in reduced mode, wake receiver feeds receive output; select off holds it recessive
// - filter holds receive recessive until events counted
// - valid event: dominant then recessive, minimum each
// - after wake, return to mode before stop
// - all sources ORed into one interrupt
// - voltage comparator sets status; any change flags
// - voltage flags raise interrupt when enabled
// - long dominant transmit: listen-only, status, flag
// - bad clear keeps listen-only, flag returns later
// - good clear returns normal after recovery delay
// - overcurrent only while dominant, sets flag directly
// - overcurrent and timeout flags raise interrupt only when enabled
// - filter select: off, pass, mask one, two
// - filter acts only after stop entry
// - high voltage or overcurrent: listen-only at once
// - driver off while high failure; auto re-enable
// - low-line low failure disables only low driver
// - overcurrent latches driver off until flags cleared
// - listen-only: transmitter off, rest keeps working
// - standby stops timeout counter and monitors
module can_phy_fault_wakeup_ctrl (
   input wire logic I_CLOCK,
   input wire logic I_RST,
   input wire logic I_ENABLE,
   input wire logic I_REDUCED_PERF_MODE,
   input wire logic I_STOP_ENTERED,
   input wire logic [1:0] I_WAKE_FILTER_SEL,
   input wire logic I_PHY_TX_IN,
   input wire logic I_PREC_RX,
   input wire logic I_WAKE_RX,
   input wire can_phy_pkg::volt_t I_VOLT_CMP,
   input wire can_phy_pkg::oc_t I_OC_CMP,
   input wire logic I_VOLT_FAIL_IRQ_EN,
   input wire logic I_DOM_TIMEOUT_IRQ_EN,
   input wire logic I_OVERCURRENT_IRQ_EN,
   input wire logic I_FLAG_CLR_WR,
   input wire can_phy_pkg::flags_t I_FLAG_CLR_DATA,
   output logic O_PHY_RX_OUT,
   output logic O_PHY_IRQ,
   output can_phy_pkg::flags_t O_FLAGS,
   output can_phy_pkg::volt_t O_VOLT_STATUS,
   output logic O_DOM_TIMEOUT_STATUS,
   output can_phy_pkg::mode_t O_MODE,
   output logic O_HI_DRV_EN,
   output logic O_LO_DRV_EN,
   output logic O_TX_DOMINANT
);
   can_phy_pkg::ctrl_state_t s_q;
   can_phy_pkg::ctrl_state_t s_d;
   can_phy_pkg::flags_t clr;
   can_phy_pkg::flags_t set;
   can_phy_pkg::volt_t vchg;
   logic mon;
   logic tx_active;
   logic drive_dom;
   logic dt_evt;
   logic dt_clr;
   logic fault_listen;
   logic filt_rx;
   logic filt_armed;

   // ----------------------------------------------------------------
   // wake-up filter
   // ----------------------------------------------------------------
   assign filt_armed = (s_q.mode == can_phy_pkg::MODE_STANDBY) && I_STOP_ENTERED;

   wake_pulse_filter u_wake (
      .i_clock(I_CLOCK),
      .i_rst(I_RST),
      .i_armed(filt_armed),
      .i_sel(I_WAKE_FILTER_SEL),
      .i_rx(I_WAKE_RX),
      .o_rx(filt_rx)
   );

   // ----------------------------------------------------------------
   // driver control
   // ----------------------------------------------------------------
   assign tx_active = (s_q.mode == can_phy_pkg::MODE_NORMAL) || (s_q.mode == can_phy_pkg::MODE_PSEUDO);
   assign drive_dom = tx_active && (I_PHY_TX_IN == `DOMINANT);
   assign O_HI_DRV_EN = tx_active;
   assign O_LO_DRV_EN = tx_active && (s_q.mode != can_phy_pkg::MODE_PSEUDO);
   assign O_TX_DOMINANT = drive_dom;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      // monitors sleep in shutdown and standby
      mon = (s_q.mode != can_phy_pkg::MODE_SHUTDOWN) && (s_q.mode != can_phy_pkg::MODE_STANDBY);
      clr = I_FLAG_CLR_WR ? I_FLAG_CLR_DATA : '0;
      set = '0;
      vchg = '0;
      dt_evt = 1'b0;
      dt_clr = 1'b0;
      fault_listen = 1'b0;

      if (mon) begin
         vchg = I_VOLT_CMP ^ s_q.vstat;
         s_d.vstat = I_VOLT_CMP;
         s_d.oc_prev = I_OC_CMP;
         // over-current only meaningful while pulling the bus
         set.hi_line_overcurrent_flag = drive_dom && I_OC_CMP.hi && !s_q.oc_prev.hi;
         set.lo_line_overcurrent_flag = drive_dom && I_OC_CMP.lo && !s_q.oc_prev.lo;
         if (I_PHY_TX_IN == `DOMINANT) begin
            if (s_q.dt_cnt != `CNT_W'(`DOM_TIMEOUT_CYC)) begin
               s_d.dt_cnt = s_q.dt_cnt + `CNT_W'(1);
            end else if (!s_q.dt_stat) begin
               dt_evt = 1'b1;
               s_d.dt_stat = 1'b1;
            end
         end else begin
            s_d.dt_cnt = '0;
            s_d.dt_stat = 1'b0;
         end
      end
      set.hi_line_volt_high_flag = vchg.hi_high;
      set.hi_line_volt_low_flag = vchg.hi_low;
      set.lo_line_volt_high_flag = vchg.lo_high;
      set.lo_line_volt_low_flag = vchg.lo_low;

      // timeout flag clear: recover or retry
      dt_clr = clr.dom_timeout_flag && s_q.flags.dom_timeout_flag && !dt_evt;
      if (dt_clr) begin
         s_d.rec_cnt = '0;
         if ((I_PHY_TX_IN == `RECESSIVE) && !s_q.dt_stat) begin
            s_d.rec_busy = 1'b1;
         end else begin
            s_d.retry_busy = 1'b1;
         end
      end else if (s_q.rec_busy) begin
         if (s_q.rec_cnt == `CNT_W'(`RECOVER_CYC - 1)) begin
            s_d.rec_busy = 1'b0;
            s_d.dt_lock = 1'b0;
         end else begin
            s_d.rec_cnt = s_q.rec_cnt + `CNT_W'(1);
         end
      end else if (s_q.retry_busy) begin
         if (s_q.rec_cnt == `CNT_W'(`RETRY_CYC - 1)) begin
            s_d.retry_busy = 1'b0;
            set.dom_timeout_flag = 1'b1;
         end else begin
            s_d.rec_cnt = s_q.rec_cnt + `CNT_W'(1);
         end
      end
      if (dt_evt) begin
         set.dom_timeout_flag = 1'b1;
         s_d.dt_lock = 1'b1;
         s_d.rec_busy = 1'b0;
      end

      // set wins over a same-cycle clear
      s_d.flags = (s_q.flags & ~clr) | set;

      fault_listen = s_d.vstat.hi_high || s_d.vstat.lo_high
         || s_d.flags.hi_line_overcurrent_flag || s_d.flags.lo_line_overcurrent_flag
         || s_d.dt_lock;

      case (s_q.mode)
         can_phy_pkg::MODE_SHUTDOWN: begin
            if (I_ENABLE) begin
               s_d.mode = can_phy_pkg::MODE_NORMAL;
            end
         end
         can_phy_pkg::MODE_STANDBY: begin
            if (!I_REDUCED_PERF_MODE) begin
               s_d.mode = s_q.saved;
            end
         end
         can_phy_pkg::MODE_NORMAL, can_phy_pkg::MODE_PSEUDO, can_phy_pkg::MODE_LISTEN: begin
            if (I_REDUCED_PERF_MODE) begin
               s_d.saved = s_q.mode;
               s_d.mode = can_phy_pkg::MODE_STANDBY;
            end else if (fault_listen) begin
               s_d.mode = can_phy_pkg::MODE_LISTEN;
            end else if (s_d.vstat.lo_low) begin
               s_d.mode = can_phy_pkg::MODE_PSEUDO;
            end else begin
               s_d.mode = can_phy_pkg::MODE_NORMAL;
            end
         end
         default: s_d.mode = can_phy_pkg::MODE_SHUTDOWN;
      endcase

      // receive path select; registered, so one cycle later than the pin
      if (s_q.mode == can_phy_pkg::MODE_STANDBY) begin
         s_d.rx = (I_WAKE_FILTER_SEL != `SEL_OFF) ? filt_rx : `RECESSIVE;
      end else if (s_q.mode == can_phy_pkg::MODE_SHUTDOWN) begin
         s_d.rx = `RECESSIVE;
      end else begin
         s_d.rx = I_PREC_RX;
      end
   end

   always_ff @(posedge I_CLOCK) begin
      if (I_RST) begin
         s_q <= '{mode: can_phy_pkg::MODE_SHUTDOWN, saved: can_phy_pkg::MODE_NORMAL,
                  vstat: '0, oc_prev: '0, dt_stat: 1'b0, flags: '0, dt_lock: 1'b0,
                  dt_cnt: '0, rec_cnt: '0, rec_busy: 1'b0, retry_busy: 1'b0, rx: `RECESSIVE};
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign O_PHY_IRQ = (I_VOLT_FAIL_IRQ_EN && (s_q.flags.hi_line_volt_high_flag
         || s_q.flags.hi_line_volt_low_flag || s_q.flags.lo_line_volt_high_flag
         || s_q.flags.lo_line_volt_low_flag))
      || (I_DOM_TIMEOUT_IRQ_EN && s_q.flags.dom_timeout_flag)
      || (I_OVERCURRENT_IRQ_EN && (s_q.flags.hi_line_overcurrent_flag
         || s_q.flags.lo_line_overcurrent_flag));
   assign O_PHY_RX_OUT = s_q.rx;
   assign O_FLAGS = s_q.flags;
   assign O_VOLT_STATUS = s_q.vstat;
   assign O_DOM_TIMEOUT_STATUS = s_q.dt_stat;
   assign O_MODE = s_q.mode;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge I_CLOCK);
   endclocking
   default disable iff (I_RST);

   sequence s_bad_clear;
      dt_clr && ((I_PHY_TX_IN == `DOMINANT) || s_q.dt_stat);
   endsequence
   sequence s_good_clear;
      dt_clr && (I_PHY_TX_IN == `RECESSIVE) && !s_q.dt_stat;
   endsequence

   property p_retry;
      s_bad_clear |=> s_q.retry_busy && s_q.dt_lock;
   endproperty
   a_retry: assert property (p_retry) else $error("bad clear did not retry");

   // lock drops at the recovery count, seen one sample later
   localparam int rec_wait = `RECOVER_CYC + 1;
   property p_recover;
      s_good_clear |-> ##[1:rec_wait] !s_q.dt_lock;
   endproperty
   a_recover: assert property (p_recover) else $error("timeout lock not released");

   property p_timeout;
      $rose(s_q.dt_stat) |-> s_q.flags.dom_timeout_flag && s_q.dt_lock;
   endproperty
   a_timeout: assert property (p_timeout) else $error("timeout without flag or lock");

   property p_listen_off;
      (s_q.mode == can_phy_pkg::MODE_LISTEN) |-> !O_HI_DRV_EN && !O_LO_DRV_EN && !O_TX_DOMINANT;
   endproperty
   a_listen_off: assert property (p_listen_off) else $error("driver on in listen-only");

   property p_pseudo;
      (s_q.mode == can_phy_pkg::MODE_PSEUDO) |-> O_HI_DRV_EN && !O_LO_DRV_EN && s_q.vstat.lo_low;
   endproperty
   a_pseudo: assert property (p_pseudo) else $error("pseudo-normal drivers wrong");

   property p_oc_lock;
      (s_q.flags.hi_line_overcurrent_flag && !clr.hi_line_overcurrent_flag)
         |=> s_q.flags.hi_line_overcurrent_flag;
   endproperty
   a_oc_lock: assert property (p_oc_lock) else $error("overcurrent flag lost");

   property p_vchange;
      (mon && I_VOLT_CMP.lo_low != s_q.vstat.lo_low) |=> s_q.flags.lo_line_volt_low_flag;
   endproperty
   a_vchange: assert property (p_vchange) else $error("status change not flagged");

   property p_volt_irq;
      (I_VOLT_FAIL_IRQ_EN && s_q.flags.hi_line_volt_low_flag) |-> O_PHY_IRQ;
   endproperty
   a_volt_irq: assert property (p_volt_irq) else $error("voltage flag without interrupt");

   property p_high_fail;
      (mon && I_VOLT_CMP.hi_high && !I_REDUCED_PERF_MODE)
         |=> s_q.mode == can_phy_pkg::MODE_LISTEN;
   endproperty
   a_high_fail: assert property (p_high_fail) else $error("high failure left driver on");

   property p_standby_rx;
      (s_q.mode == can_phy_pkg::MODE_STANDBY && I_WAKE_FILTER_SEL == `SEL_OFF) |=> O_PHY_RX_OUT == `RECESSIVE;
   endproperty
   a_standby_rx: assert property (p_standby_rx) else $error("wake path not blocked");

   property p_wake_return;
      (s_q.mode == can_phy_pkg::MODE_STANDBY && !I_REDUCED_PERF_MODE) |=> s_q.mode == $past(s_q.saved);
   endproperty
   a_wake_return: assert property (p_wake_return) else $error("wrong mode after wake");
endmodule

// [bench/can_ctrl_model.sv]
// protocol controller stand-in: drives transmit and runs timeout recovery
`timescale 1ns/100ps
module can_ctrl_model (
   input wire logic i_clock,
   input wire logic i_auto,
   input wire logic i_dom_req,
   input wire logic i_dt_flag,
   input wire logic i_dt_status,
   output logic o_tx,
   output logic o_clr,
   output logic o_fail
);
   logic req;
   logic go;
   int n;
   initial begin
      o_tx = 1'h1;
      o_clr = 1'h0;
      o_fail = 1'h0;
      forever begin
         @(posedge i_clock);
         req = i_dom_req;
         go = i_auto && i_dt_flag;
         @(negedge i_clock);
         if (go) begin
            o_tx = 1'h1;
            n = 0;
            // give up after 3 us and report, never hang on a stuck status
            while (i_dt_status && n < 375) begin
               @(negedge i_clock);
               n++;
            end
            o_fail = i_dt_status;
            o_clr = 1'h1;
            @(negedge i_clock);
            o_clr = 1'h0;
            repeat (250) @(negedge i_clock);
         end else begin
            o_tx = ~req;
         end
      end
   end
endmodule

// [bench/can_phy_fault_wakeup_ctrl_test.sv]
// self-checking bench for the transceiver fault and wake-up control
`timescale 1ns/100ps
module can_phy_fault_wakeup_ctrl_test;
   logic clk = 1'h0, rst = 1'h1, en = 1'h0, reduced_perf_mode = 1'h0, stp = 1'h0, prx = 1'h1, wrx = 1'h1;
   logic vfe = 1'h0, dte = 1'h0, oce = 1'h0, clr_wr = 1'h0, dom_req = 1'h0, auto_rec = 1'h0;
   logic [1:0] sel = 2'h0;
   logic [15:0] rnd = 16'h9049;
   can_phy_pkg::volt_t vcmp = 4'h0, vstat;
   can_phy_pkg::oc_t occ = 2'h0;
   can_phy_pkg::flags_t clr_data = 7'h00, flags;
   can_phy_pkg::mode_t mode;
   logic tx, m_clr, m_fail, rx_out, irq, dt_stat, hidrv, lodrv, txdom;
   int n_fail = 0, samples_checked = 0;
   always #4 clk = ~clk;
   can_ctrl_model partner (.i_clock(clk), .i_auto(auto_rec), .i_dom_req(dom_req), .i_dt_flag(flags[2]),
      .i_dt_status(dt_stat), .o_tx(tx), .o_clr(m_clr), .o_fail(m_fail));
   can_phy_fault_wakeup_ctrl dut (.I_CLOCK(clk), .I_RST(rst), .I_ENABLE(en), .I_REDUCED_PERF_MODE(reduced_perf_mode),
      .I_STOP_ENTERED(stp), .I_WAKE_FILTER_SEL(sel), .I_PHY_TX_IN(tx), .I_PREC_RX(prx), .I_WAKE_RX(wrx),
      .I_VOLT_CMP(vcmp), .I_OC_CMP(occ), .I_VOLT_FAIL_IRQ_EN(vfe), .I_DOM_TIMEOUT_IRQ_EN(dte),
      .I_OVERCURRENT_IRQ_EN(oce), .I_FLAG_CLR_WR(clr_wr | m_clr),
      .I_FLAG_CLR_DATA(m_clr ? can_phy_pkg::flags_t'(7'h04) : clr_data), .O_PHY_RX_OUT(rx_out),
      .O_PHY_IRQ(irq), .O_FLAGS(flags), .O_VOLT_STATUS(vstat), .O_DOM_TIMEOUT_STATUS(dt_stat), .O_MODE(mode),
      .O_HI_DRV_EN(hidrv), .O_LO_DRV_EN(lodrv), .O_TX_DOMINANT(txdom));
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic exp_irq(input can_phy_pkg::flags_t f, input logic [2:0] e);
      return (e[2] && f[6:3] != 4'h0) || (e[1] && f[2]) || (e[0] && f[1:0] != 2'h0);
   endfunction
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask
   task automatic wait_mode(input can_phy_pkg::mode_t m, input int n);
      for (int i = 0; i < n && mode !== m; i++) tick(1);
      check(mode, m, "mode");
   endtask
   task automatic clr(input can_phy_pkg::flags_t m);
      clr_data = m;
      clr_wr = 1'h1;
      tick(1);
      clr_wr = 1'h0;
      tick(1);
   endtask
   task automatic wake_ev(input int d, input logic exp);
      wrx = 1'h0;
      tick(d);
      check(rx_out, exp, "wake rx");
      wrx = 1'h1;
      tick(130);
   endtask
   task automatic complete_run();
      $display("checks %0d, mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      #400000;
      n_fail++;
      complete_run();
   end
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   initial begin
      can_phy_pkg::volt_t vt[4] = '{4'h8, 4'h2, 4'h1, 4'h4};
      can_phy_pkg::mode_t mt[4] = '{can_phy_pkg::MODE_LISTEN, can_phy_pkg::MODE_LISTEN,
         can_phy_pkg::MODE_PSEUDO, can_phy_pkg::MODE_NORMAL};
      logic [1:0] st[4] = '{2'h0, 2'h2, 2'h1, 2'h3};
      int nm[4] = '{0, 0, 1, 2};
      can_phy_pkg::flags_t f;
      int t;
      tick(8);
      rst = 1'h0;
      check({mode, flags}, 10'h000, "reset state");
      check({rx_out, irq, hidrv, lodrv}, 4'h8, "reset outputs");
      {vfe, dte, oce} = 3'h7;
      en = 1'h1;
      wait_mode(can_phy_pkg::MODE_NORMAL, 2);
      for (int i = 0; i < 8; i++) begin
         rnd = lfsr(rnd);
         prx = rnd[0];
         tick(1);
         check(rx_out, rnd[0], "normal rx");
      end
      for (int k = 0; k < 4; k++) begin
         f = {vt[k], 3'h0};
         vcmp = vt[k];
         dom_req = 1'h1;
         tick(1);
         check({vstat, flags}, {vt[k], f}, "volt status and flag");
         check(mode, mt[k], "volt fault mode");
         for (int e = 0; e < 8; e++) begin
            {vfe, dte, oce} = e[2:0];
            tick(1);
            check(irq, exp_irq(f, e[2:0]), "irq gating");
         end
         check({hidrv, lodrv, txdom}, {k >= 2, k == 3, k >= 2}, "drivers");
         vcmp = 4'h0;
         dom_req = 1'h0;
         tick(1);
         check(vstat, 4'h0, "status follows");
         wait_mode(can_phy_pkg::MODE_NORMAL, 3);
         check(flags, f, "change sets flag");
         clr(7'h00);
         check(flags, f, "write zero keeps");
         clr(f);
         check(flags, 7'h00, "write one clears");
      end
      occ = 2'h2;
      tick(2);
      check(flags, 7'h00, "no oc when recessive");
      occ = 2'h0;
      for (int r = 0; r < 2; r++) begin
         dom_req = 1'h1;
         tick(3);
         occ = 2'h1;
         tick(1);
         check(flags, 7'h01, "oc flag");
         check({mode, txdom}, {can_phy_pkg::MODE_LISTEN, 1'h0}, "oc listen");
         occ = 2'h0;
         dom_req = 1'h0;
         tick(20);
         check(mode, can_phy_pkg::MODE_LISTEN, "oc latched");
         oce = 1'h0;
         tick(1);
         check(irq, 1'h0, "oc irq off");
         oce = 1'h1;
         tick(1);
         check(irq, 1'h1, "oc irq on");
         clr(7'h01);
         wait_mode(can_phy_pkg::MODE_NORMAL, 4);
      end
      for (int i = 0; i < 3; i++) begin
         rnd = lfsr(rnd);
         dom_req = 1'h1;
         tick(1 + rnd % 450);
         dom_req = 1'h0;
         tick(2);
         check(dt_stat, 1'h0, "short dominant");
      end
      dom_req = 1'h1;
      tick(480);
      check({dt_stat, mode}, {1'h0, can_phy_pkg::MODE_NORMAL}, "before timeout");
      for (int i = 0; i < 40 && dt_stat !== 1'h1; i++) tick(1);
      check({dt_stat, flags, mode, txdom}, {1'h1, 7'h04, can_phy_pkg::MODE_LISTEN, 1'h0}, "timeout");
      check(irq, exp_irq(7'h04, 3'h7), "timeout irq");
      clr(7'h04);
      check({flags, mode}, {7'h00, can_phy_pkg::MODE_LISTEN}, "bad clear");
      for (int i = 0; i < 270 && flags[2] !== 1'h1; i++) tick(1);
      check({flags, mode}, {7'h04, can_phy_pkg::MODE_LISTEN}, "flag again");
      dom_req = 1'h0;
      auto_rec = 1'h1;
      for (int i = 0; i < 700 && m_clr !== 1'h1; i++) @(posedge clk);
      for (t = 0; t < 300 && mode !== can_phy_pkg::MODE_NORMAL; t++) tick(1);
      check(t >= 124 && t <= 251, 1'h1, "recovery time");
      check(m_fail, 1'h0, "status cleared");
      auto_rec = 1'h0;
      for (int k = 0; k < 4; k++) begin
         sel = st[k];
         reduced_perf_mode = 1'h1;
         wait_mode(can_phy_pkg::MODE_STANDBY, 4);
         vcmp = 4'h8;
         tick(3);
         check({vstat, mode}, {4'h0, can_phy_pkg::MODE_STANDBY}, "standby monitors off");
         vcmp = 4'h0;
         wrx = 1'h0;
         tick(130);
         wrx = 1'h1;
         tick(130);
         stp = 1'h1;
         wake_ev(60, sel != 2'h2);
         for (int i = 0; i < nm[k]; i++) wake_ev(130, 1'h1);
         wake_ev(130, sel == 2'h0);
         reduced_perf_mode = 1'h0;
         stp = 1'h0;
         wait_mode(can_phy_pkg::MODE_NORMAL, 4);
      end
      complete_run();
   end
endmodule
